// File: hdl/bdm_core_regs.sv
// banked data memory decode, core registers and read path
module bdm_core_regs
    import bdm_pkg::*;
(
    // clock, reset, enable
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        por,
    // data memory access from the execution core
    input  wire logic        acc_req,
    input  wire logic        acc_we,
    input  wire logic [6:0]  acc_off,
    input  wire logic [7:0]  acc_wdata,
    output logic [7:0]       acc_rdata,
    output logic             acc_rvalid,
    // alu flag source
    input  wire bdm_alu_op_t alu_op,
    input  wire logic [7:0]  alu_a,
    input  wire logic [7:0]  alu_b,
    // power events
    input  wire logic        watchdog_clear,
    input  wire logic        sleep_exec,
    input  wire logic        watchdog_timeout,
    // register views for the core
    output logic [7:0]       status_flags,
    output logic [5:0]       bank_selector,
    output logic [7:0]       working_accumulator
);
    // ------------------------------------------------------------
    // core register storage
    // ------------------------------------------------------------
    logic [7:0] pc_low_q;
    logic [7:0] ptr0_lo_q;
    logic [7:0] ptr0_hi_q;
    logic [7:0] ptr1_lo_q;
    logic [7:0] ptr1_hi_q;
    logic [5:0] bank_sel_q;
    logic [7:0] wacc_q;
    logic [7:0] pc_latch_q;
    logic [7:0] intr_ctrl_q;
    logic [7:0] status_q;

    // ------------------------------------------------------------
    // address formation
    // ------------------------------------------------------------
    // offsets 0 and 1 redirect through the matching pointer
    wire        via_ptr  = acc_off < OFF_PCLO;
    wire        ptr_sel  = acc_off[0];
    wire [15:0] ptr      = ptr_sel ? {ptr1_hi_q, ptr1_lo_q}
                                   : {ptr0_hi_q, ptr0_lo_q};
    wire        ptr_trad = ptr[15:13] == PTR_TRAD;
    wire        ptr_lin  = (ptr[15:13] == PTR_LIN) &&
                           (ptr[12:0] < RAM_SIZE);
    wire [ADDR_W-1:0] addr = via_ptr ? ptr[12:0]
                                     : {bank_sel_q, acc_off};
    wire [5:0]  bank     = addr[ADDR_W-1:OFF_W];
    wire [6:0]  off      = addr[OFF_W-1:0];
    wire        banked   = !via_ptr || ptr_trad;

    // ------------------------------------------------------------
    // region decode
    // ------------------------------------------------------------
    // pointer aimed back at offsets 0/1 has nothing behind it
    wire sel_core = banked && (off >= OFF_PCLO) &&
                    (off < OFF_PERIPH);
    wire sel_com  = banked && (off >= OFF_COMMON);
    wire sel_bram = banked && (bank < BANK_BIG) &&
                    (off >= OFF_RAM) && (off < OFF_COMMON);
    wire sel_lin  = via_ptr && ptr_lin;
    wire sel_ram  = sel_bram || sel_lin;

    wire [RAM_AW-1:0] bank_base = RAM_AW'(bank * RAM_PER_BANK);
    wire [RAM_AW-1:0] bank_rel  = RAM_AW'(off - OFF_RAM);
    wire [RAM_AW-1:0] ram_idx   = sel_lin ? ptr[12:0]
                                          : bank_base + bank_rel;
    wire [COM_AW-1:0] com_idx   = off[COM_AW-1:0];

    wire go_wr = acc_req && acc_we;
    wire go_rd = acc_req && !acc_we;
    wire wr_core = go_wr && sel_core;

    wire wr_pclo  = wr_core && (off == OFF_PCLO);
    wire wr_stat  = wr_core && (off == OFF_STATUS);
    wire wr_p0lo  = wr_core && (off == OFF_P0LO);
    wire wr_p0hi  = wr_core && (off == OFF_P0HI);
    wire wr_p1lo  = wr_core && (off == OFF_P1LO);
    wire wr_p1hi  = wr_core && (off == OFF_P1HI);
    wire wr_bank  = wr_core && (off == OFF_BANK);
    wire wr_wacc  = wr_core && (off == OFF_WACC);
    wire wr_pclat = wr_core && (off == OFF_PCLAT);
    wire wr_intr  = wr_core && (off == OFF_INTR);

    // ------------------------------------------------------------
    // core register read selection
    // ------------------------------------------------------------
    wire [7:0] core_rd =
        (off == OFF_PCLO)   ? pc_low_q :
        (off == OFF_STATUS) ? status_q :
        (off == OFF_P0LO)   ? ptr0_lo_q :
        (off == OFF_P0HI)   ? ptr0_hi_q :
        (off == OFF_P1LO)   ? ptr1_lo_q :
        (off == OFF_P1HI)   ? ptr1_hi_q :
        (off == OFF_BANK)   ? {2'b00, bank_sel_q} :
        (off == OFF_WACC)   ? wacc_q :
        (off == OFF_PCLAT)  ? pc_latch_q :
        (off == OFF_INTR)   ? intr_ctrl_q : ZERO_BYTE;

    wire bdm_src_t src =
        sel_core ? SRC_CORE :
        sel_ram  ? SRC_RAM :
        sel_com  ? SRC_COM : SRC_ZERO;

    // ------------------------------------------------------------
    // core register writes
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst || por)
        begin
            pc_low_q    <= REG_RST;
            ptr0_lo_q   <= REG_RST;
            ptr0_hi_q   <= REG_RST;
            ptr1_lo_q   <= REG_RST;
            ptr1_hi_q   <= REG_RST;
            wacc_q      <= REG_RST;
            pc_latch_q  <= REG_RST;
            intr_ctrl_q <= REG_RST;
        end
        else if (ce)
        begin
            if (wr_pclo)  pc_low_q    <= acc_wdata;
            if (wr_p0lo)  ptr0_lo_q   <= acc_wdata;
            if (wr_p0hi)  ptr0_hi_q   <= acc_wdata;
            if (wr_p1lo)  ptr1_lo_q   <= acc_wdata;
            if (wr_p1hi)  ptr1_hi_q   <= acc_wdata;
            if (wr_wacc)  wacc_q      <= acc_wdata;
            if (wr_pclat) pc_latch_q  <= acc_wdata;
            if (wr_intr)  intr_ctrl_q <= acc_wdata;
        end
    end

    // bank selector loads at the write edge, next access sees it
    always_ff @(posedge clk_sys)
    begin
        if (rst || por)
            bank_sel_q <= BANK_W'(REG_RST);
        else if (ce && wr_bank)
            bank_sel_q <= acc_wdata[BANK_W-1:0];
    end

    // ------------------------------------------------------------
    // status register
    // ------------------------------------------------------------
    bdm_flags u_flags (
        .clk_sys          (clk_sys),
        .rst              (rst),
        .ce               (ce),
        .por              (por),
        .alu_op           (alu_op),
        .alu_a            (alu_a),
        .alu_b            (alu_b),
        .st_we            (wr_stat),
        .st_wdata         (acc_wdata),
        .watchdog_clear   (watchdog_clear),
        .sleep_exec       (sleep_exec),
        .watchdog_timeout (watchdog_timeout),
        .status_q         (status_q)
    );

    // ------------------------------------------------------------
    // general and common RAM
    // ------------------------------------------------------------
    logic [7:0] ram_rd;
    logic [7:0] com_rd;

    bdm_ram #(
        .DEPTH (RAM_DEPTH),
        .AW    (RAM_AW)
    ) u_ram (
        .clk_sys (clk_sys),
        .ce      (ce),
        .we      (go_wr && sel_ram),
        .re      (go_rd && sel_ram),
        .addr    (ram_idx),
        .wdata   (acc_wdata),
        .rdata_q (ram_rd)
    );

    bdm_ram #(
        .DEPTH (COM_DEPTH),
        .AW    (COM_AW)
    ) u_com (
        .clk_sys (clk_sys),
        .ce      (ce),
        .we      (go_wr && sel_com),
        .re      (go_rd && sel_com),
        .addr    (com_idx),
        .wdata   (acc_wdata),
        .rdata_q (com_rd)
    );

    // ------------------------------------------------------------
    // read pipeline: decode stage, then output stage
    // ------------------------------------------------------------
    logic       rd_v_q;
    bdm_src_t   src_q;
    logic [7:0] core_q;

    always_ff @(posedge clk_sys)
    begin
        if (rst || por)
        begin
            rd_v_q <= 1'b0;
            src_q  <= SRC_ZERO;
            core_q <= ZERO_BYTE;
        end
        else if (ce)
        begin
            rd_v_q <= go_rd;
            src_q  <= src;
            core_q <= core_rd;
        end
    end

    wire [7:0] rd_mux =
        (src_q == SRC_CORE) ? core_q :
        (src_q == SRC_RAM)  ? ram_rd :
        (src_q == SRC_COM)  ? com_rd : ZERO_BYTE;

    always_ff @(posedge clk_sys)
    begin
        if (rst || por)
        begin
            acc_rvalid <= 1'b0;
            acc_rdata  <= ZERO_BYTE;
        end
        else if (ce)
        begin
            acc_rvalid <= rd_v_q;
            acc_rdata  <= rd_v_q ? rd_mux : acc_rdata;
        end
    end

    // ------------------------------------------------------------
    // views for the core
    // ------------------------------------------------------------
    assign status_flags        = status_q;
    assign bank_selector       = bank_sel_q;
    assign working_accumulator = wacc_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    bank_apply_a: assert property (
        @(posedge clk_sys) disable iff (rst || por)
        (ce && wr_bank) |=> bank_sel_q == $past(acc_wdata[5:0]))
        else $error("bank select not loaded");

    direct_bank_a: assert property (
        @(posedge clk_sys) disable iff (rst || por)
        (acc_req && !via_ptr) |-> bank == bank_sel_q && off == acc_off)
        else $error("direct address not formed from bank");

    read_latency_a: assert property (
        @(posedge clk_sys) disable iff (rst || por)
        (go_rd && ce) ##1 ce |=> acc_rvalid)
        else $error("read answer missing");

    core_mirror_a: assert property (
        @(posedge clk_sys) disable iff (rst || por)
        (go_rd && ce && !via_ptr && acc_off == OFF_WACC) ##1 ce
        |=> acc_rdata == $past(wacc_q, 2))
        else $error("core register not mirrored");

    unmapped_zero_a: assert property (
        @(posedge clk_sys) disable iff (rst || por)
        (go_rd && ce && src == SRC_ZERO) ##1 ce |=> acc_rdata == ZERO_BYTE)
        else $error("unmapped read not zero");

    periph_hole_a: assert property (
        @(posedge clk_sys) disable iff (rst || por)
        (acc_req && banked && off >= OFF_PERIPH && off < OFF_RAM)
        |-> src == SRC_ZERO)
        else $error("peripheral area decoded as memory");

    common_map_a: assert property (
        @(posedge clk_sys) disable iff (rst || por)
        (acc_req && banked && off >= OFF_COMMON) |-> src == SRC_COM)
        else $error("common RAM not decoded");

    core_decode_a: assert property (
        @(posedge clk_sys) disable iff (rst || por)
        (acc_req && banked && off >= OFF_PCLO && off < OFF_PERIPH)
        |-> src == SRC_CORE)
        else $error("core offset not decoded");

    bank_ram_a: assert property (
        @(posedge clk_sys) disable iff (rst || por)
        (acc_req && !via_ptr && bank_sel_q < BANK_BIG &&
         acc_off >= OFF_RAM && acc_off < OFF_COMMON) |-> src == SRC_RAM)
        else $error("bank RAM not decoded");

    big_bank_a: assert property (
        @(posedge clk_sys) disable iff (rst || por)
        (acc_req && !via_ptr && bank_sel_q >= BANK_BIG &&
         acc_off >= OFF_PERIPH && acc_off < OFF_COMMON) |-> src == SRC_ZERO)
        else $error("wide peripheral area decoded as memory");

    linear_ram_a: assert property (
        @(posedge clk_sys) disable iff (rst || por)
        (acc_req && via_ptr && ptr[15:13] == PTR_LIN && ptr[12:0] < RAM_SIZE)
        |-> src == SRC_RAM && ram_idx == ptr[12:0])
        else $error("linear pointer not mapped to RAM");

    wacc_write_a: assert property (
        @(posedge clk_sys) disable iff (rst || por)
        (ce && wr_core && off == OFF_WACC)
        |=> working_accumulator == $past(acc_wdata))
        else $error("working register not written");

    bank_hold_a: assert property (
        @(posedge clk_sys) disable iff (rst || por)
        !(ce && wr_bank) |=> $stable(bank_sel_q))
        else $error("bank select changed without write");
endmodule

// File: hdl/bdm_pkg.sv
// package: data memory map, status layout and alu operations
package bdm_pkg;
    // ------------------------------------------------------------
    // address split
    // ------------------------------------------------------------
    localparam int BANK_W = 6;
    localparam int OFF_W  = 7;
    localparam int ADDR_W = BANK_W + OFF_W;
    localparam int RAM_AW = 13;
    localparam int COM_AW = 4;

    // ------------------------------------------------------------
    // core register offsets inside every bank
    // ------------------------------------------------------------
    localparam logic [6:0] OFF_IND0   = 7'h00;
    localparam logic [6:0] OFF_IND1   = 7'h01;
    localparam logic [6:0] OFF_PCLO   = 7'h02;
    localparam logic [6:0] OFF_STATUS = 7'h03;
    localparam logic [6:0] OFF_P0LO   = 7'h04;
    localparam logic [6:0] OFF_P0HI   = 7'h05;
    localparam logic [6:0] OFF_P1LO   = 7'h06;
    localparam logic [6:0] OFF_P1HI   = 7'h07;
    localparam logic [6:0] OFF_BANK   = 7'h08;
    localparam logic [6:0] OFF_WACC   = 7'h09;
    localparam logic [6:0] OFF_PCLAT  = 7'h0A;
    localparam logic [6:0] OFF_INTR   = 7'h0B;

    // ------------------------------------------------------------
    // bank layout
    // ------------------------------------------------------------
    localparam logic [6:0] OFF_PERIPH = 7'h0C;
    localparam logic [6:0] OFF_RAM    = 7'h20;
    localparam logic [6:0] OFF_COMMON = 7'h70;
    localparam logic [5:0] BANK_BIG   = 6'h3C;
    localparam int RAM_PER_BANK = 80;
    localparam int RAM_BANKS    = 60;
    localparam int RAM_DEPTH    = RAM_PER_BANK * RAM_BANKS;
    localparam int COM_DEPTH    = 16;
    localparam logic [12:0] RAM_SIZE = 13'(RAM_DEPTH);
    localparam logic [2:0] PTR_TRAD = 3'h0;
    localparam logic [2:0] PTR_LIN  = 3'h1;

    // ------------------------------------------------------------
    // status register layout
    // ------------------------------------------------------------
    localparam int ST_C  = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z  = 2;
    localparam int ST_PD = 3;
    localparam int ST_TO = 4;
    localparam logic [2:0] ST_UNUSED  = 3'h0;
    localparam logic [7:0] STATUS_POR = 8'h18;
    localparam logic [7:0] REG_RST    = 8'h00;
    localparam logic [7:0] ZERO_BYTE  = 8'h00;

    typedef enum logic [2:0] {
        ALU_NONE, ALU_ADD, ALU_SUB, ALU_LOGIC, ALU_RLC, ALU_RRC
    } bdm_alu_op_t;

    typedef enum logic [1:0] {
        SRC_ZERO, SRC_CORE, SRC_RAM, SRC_COM
    } bdm_src_t;
endpackage

// File: hdl/bdm_ram.sv
// byte memory with registered read data
module bdm_ram
    import bdm_pkg::*;
#(
    parameter int DEPTH = 16,
    parameter int AW    = 4
)
(
    // clock and enable
    input  wire logic          clk_sys,
    input  wire logic          ce,
    // access
    input  wire logic          we,
    input  wire logic          re,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wdata,
    output logic      [7:0]    rdata_q
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk_sys)
    begin
        if (ce && we)
            mem[addr] <= wdata;
        if (ce && re)
            rdata_q <= mem[addr];
    end
endmodule

// File: hdl/bdm_flags.sv
// alu and reset flags of the status register
module bdm_flags
    import bdm_pkg::*;
(
    // clock, reset, enable
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        por,
    // alu result source
    input  wire bdm_alu_op_t alu_op,
    input  wire logic [7:0]  alu_a,
    input  wire logic [7:0]  alu_b,
    // register write
    input  wire logic        st_we,
    input  wire logic [7:0]  st_wdata,
    // power events
    input  wire logic        watchdog_clear,
    input  wire logic        sleep_exec,
    input  wire logic        watchdog_timeout,
    output logic [7:0]       status_q
);
    // ------------------------------------------------------------
    // flag arithmetic
    // ------------------------------------------------------------
    wire       is_add = alu_op == ALU_ADD;
    wire       is_sub = alu_op == ALU_SUB;
    wire       arith  = is_add | is_sub;
    wire [7:0] b_eff  = is_sub ? ~alu_b : alu_b;
    wire [8:0] sum    = {1'b0, alu_a} + {1'b0, b_eff} + {8'h00, is_sub};
    wire [4:0] nib    = {1'b0, alu_a[3:0]} + {1'b0, b_eff[3:0]}
                        + {4'h0, is_sub};
    wire       upd_z  = arith | (alu_op == ALU_LOGIC);
    wire       upd_c  = arith | (alu_op == ALU_RLC) | (alu_op == ALU_RRC);
    wire [7:0] z_src  = arith ? sum[7:0] : alu_a;
    wire       z_new  = z_src == ZERO_BYTE;
    wire       c_new  = arith ? sum[8] :
                        (alu_op == ALU_RLC) ? alu_a[7] : alu_a[0];

    // written values lose to flag updates
    wire z_d  = upd_z ? z_new : st_we ? st_wdata[ST_Z] : status_q[ST_Z];
    wire dc_d = arith ? nib[4] : st_we ? st_wdata[ST_DC] : status_q[ST_DC];
    wire c_d  = upd_c ? c_new : st_we ? st_wdata[ST_C] : status_q[ST_C];
    // set wins over clear; writes never reach these two
    wire to_d = (watchdog_clear | sleep_exec) |
                (status_q[ST_TO] & ~watchdog_timeout);
    wire pd_d = watchdog_clear | (status_q[ST_PD] & ~sleep_exec);

    always_ff @(posedge clk_sys)
    begin
        if (por)
            status_q <= STATUS_POR;
        else if (ce)
            status_q <= {ST_UNUSED, to_d, pd_d,
                         z_d, dc_d, c_d};
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    por_value_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        por |=> status_q == STATUS_POR)
        else $error("power-on flags wrong");

    unused_zero_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        status_q[7:5] == ST_UNUSED)
        else $error("unused status bits not zero");

    logic_zero_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        (ce && !por && alu_op == ALU_LOGIC)
        |=> status_q[ST_Z] == ($past(alu_a) == ZERO_BYTE))
        else $error("zero flag wrong");

    add_carry_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        (ce && !por && is_add) |=> status_q[ST_C] ==
        (($past({1'b0, alu_a}) + $past({1'b0, alu_b})) >= 9'h100))
        else $error("add carry wrong");

    sub_borrow_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        (ce && !por && is_sub) |=>
        status_q[ST_C] == ($past(alu_a) >= $past(alu_b)) &&
        status_q[ST_DC] == ($past(alu_a[3:0]) >= $past(alu_b[3:0])))
        else $error("borrow flags wrong");

    rotate_carry_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        (ce && !por && alu_op == ALU_RLC) |=> status_q[ST_C] == $past(alu_a[7]))
        else $error("rotate carry wrong");

    flags_ro_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        (ce && !por && st_we && !watchdog_clear && !sleep_exec
         && !watchdog_timeout) |=> $stable(status_q[4:3]))
        else $error("reset flags written");

    sleep_flags_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        (ce && !por && sleep_exec && !watchdog_clear)
        |=> !status_q[ST_PD] && status_q[ST_TO])
        else $error("sleep flags wrong");

    timeout_flag_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        (ce && !por && watchdog_timeout && !watchdog_clear && !sleep_exec)
        |=> !status_q[ST_TO])
        else $error("time-out flag not cleared");
endmodule

// File: test/bdm_cpu_model.sv
// execution core model driving the data memory and flag ports
module bdm_cpu_model
    import bdm_pkg::*;
(
    // clock and answers
    input  wire logic        clk_sys,
    input  wire logic [7:0]  acc_rdata,
    input  wire logic        acc_rvalid,
    // requests
    output logic             acc_req,
    output logic             acc_we,
    output logic [6:0]       acc_off,
    output logic [7:0]       acc_wdata,
    output bdm_alu_op_t      alu_op,
    output logic [7:0]       alu_a,
    output logic [7:0]       alu_b,
    // clear, sleep, timeout
    output logic [2:0]       ev
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        {acc_req, acc_we, acc_off, acc_wdata} = '0;
        alu_op = ALU_NONE;
        {alu_a, alu_b, ev} = '0;
    end

    // direct write; a bank change is used by the next access
    task automatic wr(input logic [6:0] off, input logic [7:0] d);
        @(posedge clk_sys);
        acc_req   <= 1'b1;
        acc_we    <= 1'b1;
        acc_off   <= off;
        acc_wdata <= d;
        @(posedge clk_sys);
        acc_req   <= 1'b0;
        acc_wdata <= ~d;
    endtask

    // read answer settles just after the first edge past the taking one
    task automatic rd(input logic [6:0] off, output logic [7:0] d);
        @(posedge clk_sys);
        acc_req <= 1'b1;
        acc_we  <= 1'b0;
        acc_off <= off;
        @(posedge clk_sys);
        acc_req <= 1'b0;
        @(posedge clk_sys);
        #1 d = (acc_rvalid === 1'b1) ? acc_rdata : 8'hXX;
    endtask

    task automatic alu(input bdm_alu_op_t op, input logic [7:0] a, b,
                       input logic st, input logic [7:0] d);
        @(posedge clk_sys);
        alu_op    <= op;
        alu_a     <= a;
        alu_b     <= b;
        acc_req   <= st;
        acc_we    <= 1'b1;
        acc_off   <= OFF_STATUS;
        acc_wdata <= d;
        @(posedge clk_sys);
        alu_op    <= ALU_NONE;
        acc_req   <= 1'b0;
    endtask

    task automatic pulse(input logic [2:0] e);
        @(posedge clk_sys);
        ev <= e;
        @(posedge clk_sys);
        ev <= 3'h0;
    endtask
endmodule

// File: test/banked_data_memory_status_bench.sv
// self-checking bench for banked data memory and status flags
module banked_data_memory_status_bench
    import bdm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        clk_sys, rst, por, ce, acc_req, acc_we, acc_rvalid, st;
    logic [6:0]  acc_off;
    logic [7:0]  acc_wdata, acc_rdata, alu_a, alu_b, status_flags;
    logic [7:0]  working_accumulator, exp_st, v, d, bk, a, b;
    logic [5:0]  bank_selector;
    logic [2:0]  ev;
    logic [15:0] ptr;
    bdm_alu_op_t alu_op, op;
    int          n_mismatch = 0, check_count = 0, cycles = 0, idx;
    bdm_alu_op_t co [6] = '{ALU_ADD, ALU_SUB, ALU_SUB, ALU_LOGIC,
                            ALU_RLC, ALU_RRC};
    logic [7:0]  ca [6] = '{8'hFF, 8'h05, 8'h03, 8'h00, 8'h80, 8'h01};
    logic [7:0]  cb [6] = '{8'h01, 8'h03, 8'h05, 8'h00, 8'h00, 8'h00};
    logic [6:0]  co_off [4] = '{OFF_PCLO, OFF_WACC, OFF_PCLAT, OFF_INTR};

    bdm_core_regs dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .por(por),
        .acc_req(acc_req), .acc_we(acc_we), .acc_off(acc_off),
        .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
        .acc_rvalid(acc_rvalid), .alu_op(alu_op), .alu_a(alu_a),
        .alu_b(alu_b), .watchdog_clear(ev[2]), .sleep_exec(ev[1]),
        .watchdog_timeout(ev[0]), .status_flags(status_flags),
        .bank_selector(bank_selector),
        .working_accumulator(working_accumulator));

    bdm_cpu_model cpu (.clk_sys(clk_sys), .acc_rdata(acc_rdata),
        .acc_rvalid(acc_rvalid), .acc_req(acc_req), .acc_we(acc_we),
        .acc_off(acc_off), .acc_wdata(acc_wdata), .alu_op(alu_op),
        .alu_a(alu_a), .alu_b(alu_b), .ev(ev));

    // ------------------------------------------------------------
    // clock, timeout, checking helpers
    // ------------------------------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // expected status after one alu step
    function automatic logic [7:0] nxt(bdm_alu_op_t o, logic [7:0] x,
                                       logic [7:0] y, logic [7:0] s);
        logic [8:0] r;
        logic [4:0] n;
        r = (o == ALU_SUB) ? 9'(x) + {1'b0, ~y} + 9'h001 : 9'(x) + 9'(y);
        n = (o == ALU_SUB) ? 5'(x[3:0]) + {1'b0, ~y[3:0]} + 5'h01
                           : 5'(x[3:0]) + 5'(y[3:0]);
        case (o)
            ALU_ADD, ALU_SUB: s[2:0] = {r[7:0] == 8'h00, n[4], r[8]};
            ALU_LOGIC:        s[2] = (x == 8'h00);
            ALU_RLC:          s[0] = x[7];
            ALU_RRC:          s[0] = x[0];
            default:          s = s;
        endcase
        return s;
    endfunction

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        {rst, por, ce} = 3'b111;
        void'($urandom(32'h2fab9304));
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        por <= 1'b0;
        exp_st = STATUS_POR;
        #1 chk(status_flags, exp_st);
        cpu.rd(OFF_STATUS, v);
        chk(v, exp_st);
        for (int i = 0; i < 8; i++)
        begin
            bk = 8'($urandom);
            d = 8'($urandom);
            cpu.wr(OFF_BANK, bk);
            #1 chk(bank_selector, bk[5:0]);
            cpu.wr(co_off[i % 4], d);
            cpu.wr(7'h70 + 7'(i), ~d);
            cpu.wr(OFF_BANK, ~bk);
            cpu.rd(co_off[i % 4], v);
            chk(v, d);
            cpu.rd(7'h70 + 7'(i), v);
            chk(v, 8'(~d));
            cpu.rd(OFF_BANK, v);
            chk(v, {2'h0, ~bk[5:0]});
            cpu.rd(7'h0C, v);
            chk(v, 8'h00);
        end
        cpu.wr(OFF_WACC, 8'h5C);
        #1 chk(working_accumulator, 8'h5C);
        cpu.wr(OFF_BANK, 8'h3C);
        cpu.wr(7'h20, 8'hFF);
        cpu.rd(7'h20, v);
        chk(v, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            idx = (i == 0) ? 0 : (i == 1) ? 4799 : $urandom_range(0, 4799);
            d = 8'($urandom);
            bk = 8'(idx / 80);
            cpu.wr(OFF_BANK, bk);
            cpu.wr(7'(32'h20 + idx % 80), d);
            ptr = 16'h2000 + 16'(idx);
            cpu.wr(OFF_P0LO, ptr[7:0]);
            cpu.wr(OFF_P0HI, ptr[15:8]);
            cpu.rd(OFF_IND0, v);
            chk(v, d);
            ptr = {3'h0, bk[5:0], 7'(32'h20 + idx % 80)};
            cpu.wr(OFF_P1LO, ptr[7:0]);
            cpu.wr(OFF_P1HI, ptr[15:8]);
            cpu.rd(OFF_IND1, v);
            chk(v, d);
        end
        for (int i = 0; i < 46; i++)
        begin
            op = (i < 6) ? co[i] : bdm_alu_op_t'(3'($urandom_range(0, 5)));
            a = (i < 6) ? ca[i] : 8'($urandom);
            b = (i < 6) ? cb[i] : 8'($urandom);
            st = (i < 6) ? 1'b1 : 1'($urandom);
            d = (i < 6) ? 8'hE0 : 8'($urandom);
            if (st)
                exp_st[2:0] = d[2:0];
            exp_st = nxt(op, a, b, exp_st);
            cpu.alu(op, a, b, st, d);
            #1 chk(status_flags, exp_st);
        end
        for (int e = 1; e < 8; e++)
        begin
            cpu.pulse(3'(e));
            exp_st[ST_TO] = (e[2] | e[1]) ? 1'b1 : e[0] ? 1'b0 : exp_st[ST_TO];
            exp_st[ST_PD] = e[2] ? 1'b1 : e[1] ? 1'b0 : exp_st[ST_PD];
            #1 chk(status_flags, exp_st);
        end
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        #1 chk(status_flags, exp_st);
        chk(working_accumulator, 8'h00);
        @(posedge clk_sys);
        por <= 1'b1;
        @(posedge clk_sys);
        por <= 1'b0;
        #1 chk(status_flags, STATUS_POR);
        conclude();
    end
endmodule
